//--- rtl/power_timestamp_pll_divider_regs.sv
// power mode, timestamp, reference output and synthesizer feedback divider registers
`timescale 1ns/1ns
`default_nettype none
module power_timestamp_pll_divider_regs (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// serial control port
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	// synthesizer controls from the rest of the device
	input wire logic synth_enable_in,
	input wire logic synth_reset_in,
	input wire logic vco_tick_in,
	// power mode
	output pwr_regs_pkg::power_mode_type power_mode_select_out,
	// timestamp receiver
	output logic timestamp_receiver_enable_out,
	output logic timestamp_lvpecl_enable_out,
	// reference clock output
	output logic reference_clock_output_drive_out,
	// divider settings and divided ticks
	output logic [5:0] first_ratio_out,
	output logic [5:0] second_ratio_out,
	output logic [5:0] third_ratio_out,
	output logic sample_tick_out,
	output logic pfd_feedback_tick_out
);
	logic [7:0] power_mode_q, power_mode_d;
	logic [7:0] timestamp_q, timestamp_d;
	logic [7:0] ref_output_q, ref_output_d;
	logic [7:0] fbdiv_fs_q, fbdiv_fs_d;
	logic [7:0] fbdiv_third_q, fbdiv_third_d;
	pwr_regs_pkg::reg_write_type wr;
	logic wr_strobe;
	logic [14:0] rd_addr;
	logic [7:0] rd_data;
	pwr_regs_pkg::power_mode_type mode_q, mode_d;
	logic drive_q, drive_d;
	logic [5:0] ratio [pwr_regs_pkg::STAGES];
	logic [5:0] cnt_q [pwr_regs_pkg::STAGES];
	logic [5:0] cnt_d [pwr_regs_pkg::STAGES];
	logic [pwr_regs_pkg::STAGES:0] tick;
	logic [pwr_regs_pkg::STAGES:1] tick_q, tick_d;

	function automatic logic [5:0] first_ratio(input logic [1:0] code);
		unique case (code)
			2'h0: first_ratio = pwr_regs_pkg::RATIO_5;
			2'h1: first_ratio = pwr_regs_pkg::RATIO_4;
			2'h2: first_ratio = pwr_regs_pkg::RATIO_3;
			2'h3: first_ratio = pwr_regs_pkg::RATIO_HALT;
		endcase
	endfunction : first_ratio

	function automatic logic [5:0] second_ratio(input logic [1:0] code);
		unique case (code)
			2'h0: second_ratio = pwr_regs_pkg::RATIO_1;
			2'h1: second_ratio = pwr_regs_pkg::RATIO_2;
			2'h2: second_ratio = pwr_regs_pkg::RATIO_4;
			2'h3: second_ratio = pwr_regs_pkg::RATIO_HALT;
		endcase
	endfunction : second_ratio

	serial_port_slave port (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sclk_in(sclk_in),
		.cs_n_in(cs_n_in),
		.sdi_in(sdi_in),
		.sdo_out(sdo_out),
		.sdo_oe_out(sdo_oe_out),
		.wr_out(wr),
		.wr_strobe_out(wr_strobe),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data)
	);

	// reserved bits are stored as written; the host keeps them at reset value
	always_comb begin
		power_mode_d = power_mode_q;
		timestamp_d = timestamp_q;
		ref_output_d = ref_output_q;
		fbdiv_fs_d = fbdiv_fs_q;
		fbdiv_third_d = fbdiv_third_q;
		if (wr_strobe) begin
			unique case (wr.addr)
				pwr_regs_pkg::OFS_POWER_MODE: power_mode_d = wr.data;
				pwr_regs_pkg::OFS_TIMESTAMP: timestamp_d = wr.data;
				pwr_regs_pkg::OFS_REF_OUTPUT: ref_output_d = wr.data;
				pwr_regs_pkg::OFS_FBDIV_FIRST_SECOND: fbdiv_fs_d = wr.data;
				pwr_regs_pkg::OFS_FBDIV_THIRD: fbdiv_third_d = wr.data;
				default: ;
			endcase
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		unique case (rd_addr)
			pwr_regs_pkg::OFS_POWER_MODE: rd_data = power_mode_q;
			pwr_regs_pkg::OFS_TIMESTAMP: rd_data = timestamp_q;
			pwr_regs_pkg::OFS_REF_OUTPUT: rd_data = ref_output_q;
			pwr_regs_pkg::OFS_FBDIV_FIRST_SECOND: rd_data = fbdiv_fs_q;
			pwr_regs_pkg::OFS_FBDIV_THIRD: rd_data = fbdiv_third_q;
			default: rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			power_mode_q <= pwr_regs_pkg::RST_POWER_MODE;
			timestamp_q <= pwr_regs_pkg::RST_TIMESTAMP;
			ref_output_q <= pwr_regs_pkg::RST_REF_OUTPUT;
			fbdiv_fs_q <= pwr_regs_pkg::RST_FBDIV_FIRST_SECOND;
			fbdiv_third_q <= pwr_regs_pkg::RST_FBDIV_THIRD;
		end else begin
			power_mode_q <= power_mode_d;
			timestamp_q <= timestamp_d;
			ref_output_q <= ref_output_d;
			fbdiv_fs_q <= fbdiv_fs_d;
			fbdiv_third_q <= fbdiv_third_d;
		end
	end

	// mode decode; calibration ordering around a change is the host's job
	always_comb begin
		if (power_mode_q == pwr_regs_pkg::PM_CODE_LOW) begin
			mode_d = pwr_regs_pkg::MODE_LOW_POWER;
		end else if (power_mode_q == pwr_regs_pkg::PM_CODE_HIGH) begin
			mode_d = pwr_regs_pkg::MODE_HIGH_PERF;
		end else begin
			mode_d = pwr_regs_pkg::MODE_RESERVED;
		end
		drive_d = ref_output_q[pwr_regs_pkg::REFO_EN_BIT] & synth_enable_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mode_q <= pwr_regs_pkg::MODE_HIGH_PERF;
			drive_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			drive_q <= drive_d;
		end
	end

	// divider chain: vco -> first -> second (sampling) -> third (pfd feedback)
	always_comb begin
		ratio[0] = first_ratio(fbdiv_fs_q[pwr_regs_pkg::V_DIV_LSB +: 2]);
		ratio[1] = second_ratio(fbdiv_fs_q[pwr_regs_pkg::P_DIV_LSB +: 2]);
		ratio[2] = fbdiv_third_q[pwr_regs_pkg::N_DIV_LSB +: 6];
	end

	// counters stay cleared during synthesizer reset, which is when dividers may change
	always_comb begin
		tick[0] = vco_tick_in;
		for (int i = 0; i < pwr_regs_pkg::STAGES; i++) begin
			cnt_d[i] = cnt_q[i];
			tick[i+1] = 1'b0;
			if (synth_reset_in || !synth_enable_in) begin
				cnt_d[i] = 6'h00;
			end else if (tick[i] && ratio[i] != pwr_regs_pkg::RATIO_HALT) begin
				if (cnt_q[i] >= ratio[i] - 6'h01) begin
					cnt_d[i] = 6'h00;
					tick[i+1] = 1'b1;
				end else begin
					cnt_d[i] = cnt_q[i] + 6'h01;
				end
			end
		end
		tick_d = tick[pwr_regs_pkg::STAGES:1];
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < pwr_regs_pkg::STAGES; i++) begin
				cnt_q[i] <= 6'h00;
			end
			tick_q <= '0;
		end else begin
			for (int i = 0; i < pwr_regs_pkg::STAGES; i++) begin
				cnt_q[i] <= cnt_d[i];
			end
			tick_q <= tick_d;
		end
	end

	assign power_mode_select_out = mode_q;
	assign timestamp_receiver_enable_out = timestamp_q[pwr_regs_pkg::TS_RECV_EN_BIT];
	assign timestamp_lvpecl_enable_out = timestamp_q[pwr_regs_pkg::TS_LVPECL_EN_BIT];
	assign reference_clock_output_drive_out = drive_q;
	assign first_ratio_out = ratio[0];
	assign second_ratio_out = ratio[1];
	assign third_ratio_out = ratio[2];
	assign sample_tick_out = tick_q[2];
	assign pfd_feedback_tick_out = tick_q[3];

endmodule : power_timestamp_pll_divider_regs
`default_nettype wire

//--- rtl/pwr_regs_pkg.sv
// constants and types for the power, timestamp and synthesizer divider register group
//
// Contract
// - mode code 0x46 selects low power (up to 1 GSPS), 0x4B high performance, others reserved.
// - timestamp control bit 0 enables the timestamp receiver; disabled after reset.
// - reference clock output driven only while its enable and synthesizer enable are set.
// - reference clock output enable resets to one so output starts without writes.
// - second divider divides by 1, 2, 4 for codes 0-2; 3 reserved; reset 0.
// - first divider divides by 5, 4, 3 for codes 0-2; 3 reserved; reset 0.
// - third divider divides sampling clock by 6-bit value 1..63; resets to 32.
package pwr_regs_pkg;

	// serial frame: read flag, 15-bit address, 8-bit data, msb first
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [4:0] HEADER_BITS = 5'h10;

	// register offsets
	localparam logic [14:0] OFS_POWER_MODE = 15'h0037;
	localparam logic [14:0] OFS_TIMESTAMP = 15'h003b;
	localparam logic [14:0] OFS_REF_OUTPUT = 15'h003c;
	localparam logic [14:0] OFS_FBDIV_FIRST_SECOND = 15'h003d;
	localparam logic [14:0] OFS_FBDIV_THIRD = 15'h003e;

	// reset values
	localparam logic [7:0] RST_POWER_MODE = 8'h4b;
	localparam logic [7:0] RST_TIMESTAMP = 8'h00;
	localparam logic [7:0] RST_REF_OUTPUT = 8'h01;
	localparam logic [7:0] RST_FBDIV_FIRST_SECOND = 8'h00;
	localparam logic [7:0] RST_FBDIV_THIRD = 8'h20;

	// field positions
	localparam int TS_RECV_EN_BIT = 0;
	localparam int TS_LVPECL_EN_BIT = 1;
	localparam int REFO_EN_BIT = 0;
	localparam int V_DIV_LSB = 0;
	localparam int P_DIV_LSB = 2;
	localparam int N_DIV_LSB = 0;

	// power mode codes
	localparam logic [7:0] PM_CODE_LOW = 8'h46;
	localparam logic [7:0] PM_CODE_HIGH = 8'h4b;

	// divider ratios, zero marks a reserved code and halts the stage
	localparam int STAGES = 3;
	localparam logic [5:0] RATIO_HALT = 6'h00;
	localparam logic [5:0] RATIO_1 = 6'h01;
	localparam logic [5:0] RATIO_2 = 6'h02;
	localparam logic [5:0] RATIO_3 = 6'h03;
	localparam logic [5:0] RATIO_4 = 6'h04;
	localparam logic [5:0] RATIO_5 = 6'h05;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} reg_write_type;

	typedef enum logic [1:0] {
		MODE_HIGH_PERF = 2'b00,
		MODE_LOW_POWER = 2'b01,
		MODE_RESERVED = 2'b10
	} power_mode_type;

endpackage : pwr_regs_pkg

//--- rtl/serial_port_slave.sv
// serial control port slave: frame capture, write strobe and read shift-out
`timescale 1ns/1ns
`default_nettype none
module serial_port_slave (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// serial pins
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	// register side
	output pwr_regs_pkg::reg_write_type wr_out,
	output logic wr_strobe_out,
	output logic [pwr_regs_pkg::ADDR_W-1:0] rd_addr_out,
	input wire logic [pwr_regs_pkg::DATA_W-1:0] rd_data_in
);
	logic [1:0] sclk_s1_q, sclk_s1_d;
	logic [2:1] sclk_s_q, sclk_s_d;
	logic cs_s1_q, cs_s2_q, sdi_s1_q, sdi_s2_q;
	logic [4:0] count_q, count_d;
	logic [23:0] shift_q, shift_d;
	logic [7:0] out_q, out_d;
	logic read_q, read_d;
	pwr_regs_pkg::reg_write_type wr_q, wr_d;
	logic strobe_q, strobe_d;
	logic rise, fall;

	// the two-flop s1 stage only feeds sclk_s_q; edges are taken from the third and fourth stages
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sclk_s1_q <= 2'h0;
			sclk_s_q <= 2'h0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
		end else begin
			sclk_s1_q <= sclk_s1_d;
			sclk_s_q <= sclk_s_d;
			cs_s1_q <= cs_n_in;
			cs_s2_q <= cs_s1_q;
			sdi_s1_q <= sdi_in;
			sdi_s2_q <= sdi_s1_q;
		end
	end

	always_comb begin
		sclk_s1_d = {sclk_s1_q[0], sclk_in};
		sclk_s_d = {sclk_s_q[1], sclk_s1_q[1]};
	end

	assign rise = sclk_s_q[1] & ~sclk_s_q[2];
	assign fall = ~sclk_s_q[1] & sclk_s_q[2];

	always_comb begin
		count_d = count_q;
		shift_d = shift_q;
		out_d = out_q;
		read_d = read_q;
		wr_d = wr_q;
		strobe_d = 1'b0;
		if (cs_s2_q) begin
			count_d = 5'h00;
			read_d = 1'b0;
		end else if (rise && count_q != pwr_regs_pkg::FRAME_BITS) begin
			shift_d = {shift_q[22:0], sdi_s2_q};
			count_d = count_q + 5'h01;
			if (count_q == 5'h00) begin
				read_d = sdi_s2_q;
			end
			if (count_d == pwr_regs_pkg::FRAME_BITS && !read_q) begin
				wr_d.addr = shift_d[22:8];
				wr_d.data = shift_d[7:0];
				strobe_d = 1'b1;
			end
		end else if (fall && count_q == pwr_regs_pkg::HEADER_BITS) begin
			// fetch on the falling edge: the last address bit is in shift_q only by then
			out_d = rd_data_in;
		end else if (fall && count_q > pwr_regs_pkg::HEADER_BITS) begin
			out_d = {out_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_q <= 5'h00;
			shift_q <= 24'h000000;
			out_q <= 8'h00;
			read_q <= 1'b0;
			wr_q <= '0;
			strobe_q <= 1'b0;
		end else begin
			count_q <= count_d;
			shift_q <= shift_d;
			out_q <= out_d;
			read_q <= read_d;
			wr_q <= wr_d;
			strobe_q <= strobe_d;
		end
	end

	assign rd_addr_out = shift_q[14:0];
	assign sdo_out = out_q[7];
	assign sdo_oe_out = ~cs_s2_q & read_q & (count_q >= pwr_regs_pkg::HEADER_BITS);
	assign wr_out = wr_q;
	assign wr_strobe_out = strobe_q;

endmodule : serial_port_slave
`default_nettype wire

//--- verification/power_timestamp_pll_divider_regs_asserts.sv
// concurrent checks on the register group's outputs
`timescale 1ns/1ns
`default_nettype none
module power_regs_asserts (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// synthesizer controls
	input wire logic synth_enable_in,
	input wire logic synth_reset_in,
	// observed outputs
	input wire pwr_regs_pkg::power_mode_type power_mode_select_out,
	input wire logic timestamp_receiver_enable_out,
	input wire logic reference_clock_output_drive_out,
	input wire logic [5:0] first_ratio_out,
	input wire logic [5:0] second_ratio_out,
	input wire logic [5:0] third_ratio_out,
	input wire logic sample_tick_out,
	input wire logic pfd_feedback_tick_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_mode_legal;
		power_mode_select_out != 2'b11;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("mode encoding out of range");
	property p_drive_needs_synth;
		reference_clock_output_drive_out |-> $past(synth_enable_in);
	endproperty
	a_drive_needs_synth: assert property (p_drive_needs_synth) else $error("refclk driven without synth");
	property p_first_legal;
		first_ratio_out inside {6'h05, 6'h04, 6'h03, 6'h00};
	endproperty
	a_first_legal: assert property (p_first_legal) else $error("first ratio illegal");
	property p_second_legal;
		second_ratio_out inside {6'h01, 6'h02, 6'h04, 6'h00};
	endproperty
	a_second_legal: assert property (p_second_legal) else $error("second ratio illegal");
	property p_reset_values;
		$fell(rst_in) |-> !timestamp_receiver_enable_out && third_ratio_out == 6'h20 && first_ratio_out == 6'h05;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
	property p_refo_reset;
		$fell(rst_in) && synth_enable_in |=> reference_clock_output_drive_out;
	endproperty
	a_refo_reset: assert property (p_refo_reset) else $error("refclk not up after reset");
	property p_synth_halt;
		synth_reset_in ##1 synth_reset_in |=> !sample_tick_out && !pfd_feedback_tick_out;
	endproperty
	a_synth_halt: assert property (p_synth_halt) else $error("ticks during synth reset");
	property p_first_halt;
		(first_ratio_out == 6'h00) [*4] |-> !sample_tick_out;
	endproperty
	a_first_halt: assert property (p_first_halt) else $error("tick with reserved first code");
	property p_third_halt;
		(third_ratio_out == 6'h00) [*4] |-> !pfd_feedback_tick_out;
	endproperty
	a_third_halt: assert property (p_third_halt) else $error("tick with zero third ratio");

	c_sample: cover property (sample_tick_out);
	c_pfd: cover property (pfd_feedback_tick_out);
	c_low: cover property (power_mode_select_out == pwr_regs_pkg::MODE_LOW_POWER);
endmodule : power_regs_asserts
`default_nettype wire

//--- verification/power_timestamp_pll_divider_regs_tb_top.sv
// serial-port driven testbench for the power and divider register group
`timescale 1ns/1ns
`default_nettype none
module power_timestamp_pll_divider_regs_tb_top;
	logic clk_in, rst_in, sclk, cs_n, sdi, synth_en, synth_rst, vco_tick;
	logic sdo_out, sdo_oe_out, ts_en, ts_pecl, drive, s_tick, p_tick;
	logic [5:0] r1, r2, r3;
	pwr_regs_pkg::power_mode_type mode;
	logic [7:0] q;
	int fails, total_checks;
	logic [14:0] ofs [5] = '{15'h0037, 15'h003b, 15'h003c, 15'h003d, 15'h003e};
	logic [7:0] rstv [5] = '{8'h4b, 8'h00, 8'h01, 8'h00, 8'h20};

	power_timestamp_pll_divider_regs dut (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.sdi_in(sdi), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .synth_enable_in(synth_en),
		.synth_reset_in(synth_rst), .vco_tick_in(vco_tick), .power_mode_select_out(mode),
		.timestamp_receiver_enable_out(ts_en), .timestamp_lvpecl_enable_out(ts_pecl),
		.reference_clock_output_drive_out(drive), .first_ratio_out(r1), .second_ratio_out(r2),
		.third_ratio_out(r3), .sample_tick_out(s_tick), .pfd_feedback_tick_out(p_tick));

	always #25 clk_in = ~clk_in;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one 24-bit frame; sclk phases of 5 clk keep clear of the synchroniser lag
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rq);
		logic [23:0] f;
		f = {rd, a, wd};
		rq = 8'h00;
		cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi <= f[i];
			repeat (5) @(posedge clk_in);
			if (i < 8) rq[i] = sdo_out;
			sclk <= 1'b1;
			repeat (5) @(posedge clk_in);
			sclk <= 1'b0;
		end
		repeat (5) @(posedge clk_in);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask : xfer

	// cycles between two ticks; vco_tick stands high, so one tick per clock
	task automatic period(input logic sel, input logic [15:0] exp);
		int n;
		n = 0;
		while ((sel ? p_tick : s_tick) !== 1'b1 && n < 600) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while ((sel ? p_tick : s_tick) !== 1'b1 && n < 600);
		check(n[15:0], exp);
		if (n >= 600) complete_run();
	endtask : period

	initial begin
		logic [5:0] t1 [4] = '{6'h05, 6'h04, 6'h03, 6'h00};
		logic [5:0] t2 [4] = '{6'h01, 6'h02, 6'h04, 6'h00};
		logic [7:0] pm [3] = '{8'h46, 8'h4b, 8'h47};
		pwr_regs_pkg::power_mode_type pe [3];
		pe = '{pwr_regs_pkg::MODE_LOW_POWER, pwr_regs_pkg::MODE_HIGH_PERF, pwr_regs_pkg::MODE_RESERVED};
		clk_in = 1'b0;
		rst_in = 1'b1;
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		synth_en = 1'b1;
		synth_rst = 1'b0;
		vco_tick = 1'b1;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		check(drive, 1'b1);
		check(mode, pwr_regs_pkg::MODE_HIGH_PERF);
		check({r1, r2, r3}, {6'h05, 6'h01, 6'h20});
		check(ts_en, 1'b0);
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, ofs[i], 8'h00, q);
			check(q, rstv[i]);
		end
		xfer(1'b1, 15'h0038, 8'h00, q);
		check(q, 8'h00);
		check(sdo_oe_out, 1'b0);
		// calibration and link enables live outside this block and stay clear
		for (int i = 0; i < 3; i++) begin
			xfer(1'b0, 15'h0037, pm[i], q);
			check(mode, pe[i]);
		end
		xfer(1'b0, 15'h003b, 8'h01, q);
		check({ts_en, ts_pecl}, 2'b10);
		xfer(1'b0, 15'h003b, 8'h02, q);
		check({ts_en, ts_pecl}, 2'b01);
		xfer(1'b0, 15'h003c, 8'h00, q);
		check(drive, 1'b0);
		xfer(1'b0, 15'h003c, 8'h01, q);
		check(drive, 1'b1);
		synth_en <= 1'b0;
		repeat (3) @(posedge clk_in);
		check(drive, 1'b0);
		synth_en <= 1'b1;
		synth_rst <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			xfer(1'b0, 15'h003d, {4'h0, c[1:0], c[1:0]}, q);
			check({r1, r2}, {t1[c], t2[c]});
		end
		xfer(1'b0, 15'h003d, 8'h05, q);
		xfer(1'b0, 15'h003e, 8'h03, q);
		check(r3, 6'h03);
		synth_rst <= 1'b0;
		period(1'b0, 16'd8);
		period(1'b1, 16'd24);
		synth_rst <= 1'b1;
		xfer(1'b0, 15'h003e, 8'h00, q);
		check(r3, 6'h00);
		xfer(1'b0, 15'h003e, 8'h3f, q);
		check(r3, 6'h3f);
		synth_rst <= 1'b0;
		period(1'b1, 16'd504);
		complete_run();
	end
endmodule : power_timestamp_pll_divider_regs_tb_top

bind power_timestamp_pll_divider_regs power_regs_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.synth_enable_in(synth_enable_in), .synth_reset_in(synth_reset_in), .power_mode_select_out(power_mode_select_out),
	.timestamp_receiver_enable_out(timestamp_receiver_enable_out),
	.reference_clock_output_drive_out(reference_clock_output_drive_out), .first_ratio_out(first_ratio_out),
	.second_ratio_out(second_ratio_out), .third_ratio_out(third_ratio_out), .sample_tick_out(sample_tick_out),
	.pfd_feedback_tick_out(pfd_feedback_tick_out));
`default_nettype wire
